// ==== verif/fbp_host_model.sv ====
// Purpose: Requester standing for instruction fetch, data bus and debugger
// Assumes: One request at a time, held until the edge that takes it
// Notes:   Released fields other than op carry inverted values so stale data is not seen
`timescale 1ns/10ps
module fbp_host_model (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rvalid,
  input  wire logic                           i_deny,
  input  wire logic [fbp_pkg::FBP_DATA_W-1:0] i_rdata,
  output fbp_pkg::fbp_req_s                   o_req
);
  initial o_req = '0;

  task automatic xfer(input fbp_pkg::fbp_op_e op, input logic [15:0] a,
                      input logic [31:0] d, output logic rv, output logic dn,
                      output logic [31:0] rd);
    @(posedge i_clk_sys);
    o_req <= '{valid: 1'h1, op: op, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_req <= '{valid: 1'h0, op: op, addr: ~a, wdata: ~d};
    #1;
    rv = i_rvalid;
    dn = i_deny;
    rd = i_rdata;
  endtask
endmodule

// ==== verif/flash_block_protection_bench.sv ====
// Purpose: Self-checking bench for the flash protection block
// Assumes: Host model issues each request and returns the answer
// Notes:   Covers program, read, block erase and both protection kinds
`timescale 1ns/10ps
module flash_block_protection_bench;
  logic                            i_clk_sys;
  logic                            i_rst;
  logic                            i_viol_clr;
  fbp_pkg::fbp_req_s               req;
  fbp_pkg::fbp_prot_s              prot;
  logic                            rvalid, deny, viol, busy, done, rv, dn;
  logic [31:0]                     rdata, rd;
  logic [fbp_pkg::FBP_UNITS-1:0]   ro_map, xo_map;
  int                              error_cnt = 0;
  int                              num_checks = 0;

  fbp_flash_protect u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req),
    .i_prot(prot), .i_viol_clr(i_viol_clr), .o_rvalid_ff(rvalid), .o_rdata(rdata),
    .o_deny_ff(deny), .o_viol_ff(viol), .o_busy_ff(busy), .o_done_ff(done),
    .o_ro_map_ff(ro_map), .o_xo_map_ff(xo_map));
  fbp_host_model u_host (.i_clk_sys(i_clk_sys), .i_rvalid(rvalid), .i_deny(deny),
    .i_rdata(rdata), .o_req(req));

  initial begin
    i_clk_sys = 1'h0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic acc(input fbp_pkg::fbp_op_e op, input logic [15:0] a, input logic [31:0] d,
                     input logic e_rv, input logic e_dn, input logic [31:0] e_rd);
    logic wr;
    wr = (op == fbp_pkg::FBP_OP_PROG) || (op == fbp_pkg::FBP_OP_ERASE);
    u_host.xfer(op, a, d, rv, dn, rd);
    chk(32'({rv, dn, done}), 32'({e_rv, e_dn, op == fbp_pkg::FBP_OP_PROG && !e_dn}), "answer");
    if (!wr || e_dn) chk(rd, e_rd, "read data");
    if (e_dn) chk(32'(viol), 32'h1, "violation flag");
  endtask

  task automatic set_prot(input logic [6:0] u, input logic ro, input logic xo);
    @(posedge i_clk_sys);
    prot <= '{wr: 1'h1, unit: u, ro: ro, xo: xo};
    @(posedge i_clk_sys);
    prot <= '{wr: 1'h0, unit: u, ro: ro, xo: xo};
    #1;
  endtask

  task automatic t_rw;
    fbp_pkg::fbp_op_e rops[3] = '{fbp_pkg::FBP_OP_FETCH, fbp_pkg::FBP_OP_DREAD,
                                  fbp_pkg::FBP_OP_DBG_READ};
    chk(32'({rvalid, deny, viol, busy, done, |ro_map, |xo_map}), 32'h0, "reset");
    acc(fbp_pkg::FBP_OP_PROG, 16'h0600, 32'h12345678, 1'h0, 1'h0, 32'h0);
    acc(fbp_pkg::FBP_OP_PROG, 16'h06FF, 32'h5A5A5A5A, 1'h0, 1'h0, 32'h0);
    acc(fbp_pkg::FBP_OP_PROG, 16'h0700, 32'h0BADF00D, 1'h0, 1'h0, 32'h0);
    acc(fbp_pkg::FBP_OP_PROG, 16'h0A10, 32'hC0DE0001, 1'h0, 1'h0, 32'h0);
    foreach (rops[i]) acc(rops[i], 16'h0700, 32'h0, 1'h1, 1'h0, 32'h0BADF00D);
  endtask

  task automatic t_erase;
    int n;
    acc(fbp_pkg::FBP_OP_ERASE, 16'h0634, 32'h0, 1'h0, 1'h0, 32'h0);
    n = 0;
    while (busy === 1'h1 && n < 400) begin
      n++;
      @(posedge i_clk_sys);
      #1;
    end
    chk(32'(n), 32'd256, "busy length");
    chk(32'(done), 32'h1, "erase done");
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0600, 32'h0, 1'h1, 1'h0, 32'hFFFFFFFF);
    acc(fbp_pkg::FBP_OP_DREAD, 16'h06FF, 32'h0, 1'h1, 1'h0, 32'hFFFFFFFF);
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0700, 32'h0, 1'h1, 1'h0, 32'h0BADF00D);
  endtask

  task automatic t_ro;
    set_prot(7'h03, 1'h1, 1'h0);
    chk(32'({ro_map[4:2], xo_map[3]}), 32'h4, "read-only map");
    acc(fbp_pkg::FBP_OP_PROG, 16'h0700, 32'h11111111, 1'h0, 1'h1, 32'h0);
    acc(fbp_pkg::FBP_OP_ERASE, 16'h0600, 32'h0, 1'h0, 1'h1, 32'h0);
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0700, 32'h0, 1'h1, 1'h0, 32'h0BADF00D);
    acc(fbp_pkg::FBP_OP_FETCH, 16'h06FF, 32'h0, 1'h1, 1'h0, 32'hFFFFFFFF);
    @(posedge i_clk_sys);
    i_viol_clr <= 1'h1;
    @(posedge i_clk_sys);
    i_viol_clr <= 1'h0;
    #1;
    chk(32'(viol), 32'h0, "violation clear");
  endtask

  task automatic t_xo;
    set_prot(7'h05, 1'h0, 1'h1);
    chk(32'({xo_map[6:4], ro_map[5]}), 32'h4, "execute-only map");
    acc(fbp_pkg::FBP_OP_FETCH, 16'h0A10, 32'h0, 1'h1, 1'h0, 32'hC0DE0001);
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0A10, 32'h0, 1'h0, 1'h1, 32'h0);
    acc(fbp_pkg::FBP_OP_DBG_READ, 16'h0A10, 32'h0, 1'h0, 1'h1, 32'h0);
    acc(fbp_pkg::FBP_OP_PROG, 16'h0A10, 32'h0, 1'h0, 1'h1, 32'h0);
    acc(fbp_pkg::FBP_OP_ERASE, 16'h0A00, 32'h0, 1'h0, 1'h1, 32'h0);
    @(posedge i_clk_sys);
    i_viol_clr <= 1'h1;
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0A10, 32'h0, 1'h0, 1'h1, 32'h0);
    @(posedge i_clk_sys);
    i_viol_clr <= 1'h0;
    #1;
    chk(32'(viol), 32'h0, "clear after refusal");
    set_prot(7'h05, 1'h0, 1'h0);
    acc(fbp_pkg::FBP_OP_DREAD, 16'h0A10, 32'h0, 1'h1, 1'h0, 32'hC0DE0001);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    i_rst = 1'h1;
    i_viol_clr = 1'h0;
    prot = '0;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    #1;
    t_rw;
    t_erase;
    t_ro;
    t_xo;
    report_and_stop;
  end
endmodule

// ==== verilog/fbp_flash_mem.sv ====
// Purpose: Word-wide flash storage with one write port and a registered read port
// Assumes: Write and read never target the same cycle from the caller's view
// Notes:   Array content is not reset; read data register clears on request
`timescale 1ns/10ps
module fbp_flash_mem #(
  parameter int unsigned WORDS  = fbp_pkg::FBP_WORDS,
  parameter int unsigned DATA_W = fbp_pkg::FBP_DATA_W
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst,
  input  wire logic                     i_we,
  input  wire logic [$clog2(WORDS)-1:0] i_waddr,
  input  wire logic [DATA_W-1:0]        i_wdata,
  input  wire logic                     i_re,
  input  wire logic [$clog2(WORDS)-1:0] i_raddr,
  input  wire logic                     i_rd_clr,
  output logic      [DATA_W-1:0]        o_rdata_ff
);

  generate
    if (WORDS < 2 || DATA_W < 1) begin : g_bad_param
      $error("fbp_flash_mem: WORDS must be at least 2 and DATA_W at least 1");
    end
  endgenerate

  logic [DATA_W-1:0] mem [WORDS];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata_ff <= '0;
    end else if (i_rd_clr) begin
      o_rdata_ff <= '0;
    end else if (i_re) begin
      o_rdata_ff <= mem[i_raddr];
    end
  end

endmodule

// ==== verilog/fbp_flash_protect.sv ====
// Purpose: Access control and block erase for the on-chip flash array
// Assumes: Requests and protection writes are synchronous to i_clk_sys
// Notes:   Requests presented while o_busy_ff is high are ignored
`timescale 1ns/10ps
// Notes on behaviour
// - The array holds 256 KB split into 1 KB erase blocks, each erased on its own.
// - A finished erase leaves every bit of the block at one.
// - Protection is kept per 2 KB unit of two adjacent blocks, each settable read-only or execute-only.
// - Erase or program aimed at a read-only unit is refused and the unit keeps its content.
// - Erase or program aimed at an execute-only unit is refused as well.
// - An execute-only unit returns data only to instruction fetch; processor and debugger data reads are denied.
// - A permitted read delivers its data one clock after it is taken, with no wait states.
module fbp_flash_protect (
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_rst,
  input  wire fbp_pkg::fbp_req_s                   i_req,
  input  wire fbp_pkg::fbp_prot_s                  i_prot,
  input  wire logic                                i_viol_clr,
  output logic                                     o_rvalid_ff,
  output logic      [fbp_pkg::FBP_DATA_W-1:0]      o_rdata,
  output logic                                     o_deny_ff,
  output logic                                     o_viol_ff,
  output logic                                     o_busy_ff,
  output logic                                     o_done_ff,
  output logic      [fbp_pkg::FBP_UNITS-1:0]       o_ro_map_ff,
  output logic      [fbp_pkg::FBP_UNITS-1:0]       o_xo_map_ff
);

  localparam int unsigned AW = fbp_pkg::FBP_ADDR_W;
  localparam int unsigned EW = fbp_pkg::FBP_ERASE_SH;
  localparam int unsigned BW = fbp_pkg::FBP_BLK_W;
  localparam int unsigned UW = fbp_pkg::FBP_UNIT_W;
  localparam logic [EW-1:0] CNT_LAST = EW'(fbp_pkg::FBP_ERASE_WORDS - 1);

  generate
    if (fbp_pkg::FBP_PROT_KB != 2 * fbp_pkg::FBP_ERASE_KB) begin : g_bad_pair
      $error("fbp_flash_protect: a protection unit must span two erase blocks");
    end
  endgenerate

  function automatic logic is_modify(input fbp_pkg::fbp_op_e op);
    is_modify = (op == fbp_pkg::FBP_OP_PROG) || (op == fbp_pkg::FBP_OP_ERASE);
  endfunction

  function automatic logic is_data_read(input fbp_pkg::fbp_op_e op);
    is_data_read = (op == fbp_pkg::FBP_OP_DREAD) || (op == fbp_pkg::FBP_OP_DBG_READ);
  endfunction

  fbp_pkg::fbp_st_e st_ff;
  fbp_pkg::fbp_st_e nxt_st;
  logic [BW-1:0]    blk_ff;
  logic [EW-1:0]    cnt_ff;

  // Request decode
  wire          accept    = i_req.valid && (st_ff == fbp_pkg::FBP_ST_IDLE);
  wire [UW-1:0] req_unit  = i_req.addr[AW-1 -: UW];
  wire          unit_ro   = o_ro_map_ff[req_unit];
  wire          unit_xo   = o_xo_map_ff[req_unit];
  wire          mod_req   = accept && is_modify(i_req.op);
  wire          rd_req    = accept && (is_data_read(i_req.op) ||
                                       (i_req.op == fbp_pkg::FBP_OP_FETCH));
  wire          deny_mod  = mod_req && (unit_ro || unit_xo);
  wire          deny_rd   = accept && is_data_read(i_req.op) && unit_xo;
  wire          deny      = deny_mod || deny_rd;
  wire          rd_ok     = rd_req && !deny;
  wire          prog_ok   = mod_req && !deny && (i_req.op == fbp_pkg::FBP_OP_PROG);
  wire          erase_go  = mod_req && !deny && (i_req.op == fbp_pkg::FBP_OP_ERASE);
  wire          erasing   = (st_ff == fbp_pkg::FBP_ST_ERASE);
  wire          erase_end = erasing && (cnt_ff == CNT_LAST);

  // Memory port selection
  wire                               mem_we    = prog_ok || erasing;
  wire [AW-1:0]                      mem_waddr = erasing ? {blk_ff, cnt_ff} : i_req.addr;
  wire [fbp_pkg::FBP_DATA_W-1:0]     mem_wdata = erasing ? fbp_pkg::FBP_ERASED_WORD
                                                         : i_req.wdata;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      fbp_pkg::FBP_ST_IDLE: begin
        if (erase_go) begin
          nxt_st = fbp_pkg::FBP_ST_ERASE;
        end
      end
      fbp_pkg::FBP_ST_ERASE: begin
        if (erase_end) begin
          nxt_st = fbp_pkg::FBP_ST_IDLE;
        end
      end
      default: nxt_st = fbp_pkg::FBP_ST_IDLE;
    endcase
  end

  // Erase walks one 1 KB block word by word
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_ff  <= fbp_pkg::FBP_ST_IDLE;
      blk_ff <= '0;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      blk_ff <= erase_go ? i_req.addr[AW-1 -: BW] : blk_ff;
      cnt_ff <= erasing ? cnt_ff + 1'b1 : '0;
    end
  end

  // Per-unit protection state
  logic [fbp_pkg::FBP_UNITS-1:0] nxt_ro_map;
  logic [fbp_pkg::FBP_UNITS-1:0] nxt_xo_map;

  genvar u;
  generate
    for (u = 0; u < fbp_pkg::FBP_UNITS; u++) begin : g_unit
      wire sel = i_prot.wr && (i_prot.unit == UW'(u));
      assign nxt_ro_map[u] = sel ? i_prot.ro : o_ro_map_ff[u];
      assign nxt_xo_map[u] = sel ? i_prot.xo : o_xo_map_ff[u];
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ro_map_ff <= {fbp_pkg::FBP_UNITS{fbp_pkg::FBP_RO_RST}};
      o_xo_map_ff <= {fbp_pkg::FBP_UNITS{fbp_pkg::FBP_XO_RST}};
    end else begin
      o_ro_map_ff <= nxt_ro_map;
      o_xo_map_ff <= nxt_xo_map;
    end
  end

  // Status; a denial in the clearing cycle keeps the flag set
  wire nxt_viol = deny ? 1'b1 : (i_viol_clr ? 1'b0 : o_viol_ff);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid_ff <= 1'b0;
      o_deny_ff   <= 1'b0;
      o_viol_ff   <= 1'b0;
      o_busy_ff   <= 1'b0;
      o_done_ff   <= 1'b0;
    end else begin
      o_rvalid_ff <= rd_ok;
      o_deny_ff   <= deny;
      o_viol_ff   <= nxt_viol;
      o_busy_ff   <= (nxt_st == fbp_pkg::FBP_ST_ERASE);
      o_done_ff   <= prog_ok || erase_end;
    end
  end

  fbp_flash_mem #(
    .WORDS  (fbp_pkg::FBP_WORDS),
    .DATA_W (fbp_pkg::FBP_DATA_W)
  ) u_mem (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_we       (mem_we),
    .i_waddr    (mem_waddr),
    .i_wdata    (mem_wdata),
    .i_re       (rd_ok),
    .i_raddr    (i_req.addr),
    .i_rd_clr   (deny),
    .o_rdata_ff (o_rdata)
  );

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_erase_taken;
    erase_go;
  endsequence

  sequence s_erase_run;
    o_busy_ff ##256 (!o_busy_ff && o_done_ff);
  endsequence

  erase_span_a: assert property (s_erase_taken |=> s_erase_run)
    else $error("erase did not span exactly one block of words");

  erase_ones_a: assert property (erasing |-> mem_we && (mem_wdata == '1))
    else $error("erase wrote a word that is not all ones");

  prot_set_a: assert property (i_prot.wr |=>
      o_ro_map_ff[$past(i_prot.unit)] == $past(i_prot.ro) &&
      o_xo_map_ff[$past(i_prot.unit)] == $past(i_prot.xo))
    else $error("protection unit did not take the written setting");

  ro_refuse_a: assert property (mod_req && unit_ro |-> !mem_we ##1 o_deny_ff)
    else $error("modify of read-only unit was not refused");

  xo_refuse_a: assert property (mod_req && unit_xo |-> !mem_we ##1 (o_deny_ff && !o_busy_ff))
    else $error("modify of execute-only unit was not refused");

  xo_read_a: assert property (accept && is_data_read(i_req.op) && unit_xo |=>
      o_deny_ff && !o_rvalid_ff && (o_rdata == '0))
    else $error("data read of execute-only unit returned data");

  xo_fetch_a: assert property (accept && (i_req.op == fbp_pkg::FBP_OP_FETCH) |=>
      o_rvalid_ff && !o_deny_ff)
    else $error("instruction fetch was not served");

  read_lat_a: assert property (rd_ok |=> o_rvalid_ff ##1 !o_rvalid_ff || $past(rd_ok))
    else $error("permitted read did not answer in one cycle");

  viol_sticky_a: assert property (deny |=> o_viol_ff [*2] or (o_viol_ff ##1 $past(i_viol_clr)))
    else $error("violation flag not set after a refusal");

  erase_step_a: assert property (erasing && !erase_end |=>
      erasing && o_busy_ff && (cnt_ff == $past(cnt_ff) + 1'b1))
    else $error("erase did not advance to the next word");

  blk_hold_a: assert property (erasing |=> $stable(blk_ff))
    else $error("erase block changed while erasing");

  mod_ok_a: assert property (mod_req && !unit_ro && !unit_xo |=>
      !o_deny_ff && (o_done_ff || o_busy_ff))
    else $error("modify of an unprotected unit was refused");

  refuse_resp_a: assert property (deny |=>
      o_deny_ff && o_viol_ff && !o_rvalid_ff && !o_done_ff && (o_rdata == '0))
    else $error("refused request did not answer as a refusal");

  viol_clear_a: assert property (i_viol_clr && !deny |=> !o_viol_ff)
    else $error("violation flag not cleared");

  viol_win_a: assert property (i_viol_clr && deny |=> o_viol_ff)
    else $error("clear in a refusal cycle dropped the violation flag");

endmodule

// ==== verilog/fbp_pkg.sv ====
// Purpose: Shared constants and carrier types for the flash block protection logic
// Assumes: 32-bit flash words addressed by word index
// Notes:   Each figure appears here once; the bench and the erase_span_a check repeat some as literals
package fbp_pkg;

  localparam int unsigned FBP_ARRAY_KB    = 256;
  localparam int unsigned FBP_ERASE_KB    = 1;
  localparam int unsigned FBP_PROT_KB     = 2;
  localparam int unsigned FBP_WORD_BYTES  = 4;
  localparam int unsigned FBP_DATA_W      = 32;
  localparam int unsigned FBP_WORDS       = FBP_ARRAY_KB * 1024 / FBP_WORD_BYTES;
  localparam int unsigned FBP_ADDR_W      = $clog2(FBP_WORDS);
  localparam int unsigned FBP_ERASE_WORDS = FBP_ERASE_KB * 1024 / FBP_WORD_BYTES;
  localparam int unsigned FBP_ERASE_SH    = $clog2(FBP_ERASE_WORDS);
  localparam int unsigned FBP_PROT_WORDS  = FBP_PROT_KB * 1024 / FBP_WORD_BYTES;
  localparam int unsigned FBP_PROT_SH     = $clog2(FBP_PROT_WORDS);
  localparam int unsigned FBP_UNITS       = FBP_ARRAY_KB / FBP_PROT_KB;
  localparam int unsigned FBP_UNIT_W      = FBP_ADDR_W - FBP_PROT_SH;
  localparam int unsigned FBP_BLK_W       = FBP_ADDR_W - FBP_ERASE_SH;

  // Erased state of a word and protection state after reset
  localparam logic [FBP_DATA_W-1:0] FBP_ERASED_WORD = 32'hFFFFFFFF;
  localparam logic                  FBP_RO_RST      = 1'h0;
  localparam logic                  FBP_XO_RST      = 1'h0;

  typedef enum logic [2:0] {
    FBP_OP_FETCH,
    FBP_OP_DREAD,
    FBP_OP_DBG_READ,
    FBP_OP_PROG,
    FBP_OP_ERASE
  } fbp_op_e;

  typedef enum logic {
    FBP_ST_IDLE,
    FBP_ST_ERASE
  } fbp_st_e;

  typedef struct packed {
    logic                  valid;
    fbp_op_e               op;
    logic [FBP_ADDR_W-1:0] addr;
    logic [FBP_DATA_W-1:0] wdata;
  } fbp_req_s;

  typedef struct packed {
    logic                  wr;
    logic [FBP_UNIT_W-1:0] unit;
    logic                  ro;
    logic                  xo;
  } fbp_prot_s;

endpackage
